// [include/sbp_pkg.sv]
package sbp_pkg;

   // ************************************************************
   // Status register layout
   // ************************************************************
   localparam int         WR_DISABLE_BIT = 7;
   localparam int         PROT_MSB_BIT   = 6;
   localparam int         TOP_BOTTOM_BIT = 5;
   localparam int         PROT_LO_HI_BIT = 4;
   localparam int         PROT_LO_LO_BIT = 2;
   localparam int         WEL_BIT        = 1;
   localparam int         WIP_BIT        = 0;
   localparam logic [7:0] STATUS_RESET   = 8'h00;

   // ************************************************************
   // Memory map and protection codes
   // ************************************************************
   localparam int         SECTOR_BITS    = 11;
   localparam int         SECTOR_SHIFT   = 16;
   localparam int         ADDR_BITS      = 27;
   localparam logic [3:0] CODE_NONE      = 4'h0;
   localparam logic [3:0] CODE_ALL_FIRST = 4'hc;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int OP_TIME_NS    = 2000;
   localparam int OP_CYCLES     =
      (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SBP_IDLE = 2'b01,
      SBP_BUSY = 2'b10
   } sbp_state_t;

endpackage

// [design/sbp_range_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module sbp_range_decode #(
   parameter int SECTOR_BITS = sbp_pkg::SECTOR_BITS
) (
   input  wire logic [3:0]             protectCode,
   input  wire logic                   bottomSel,
   input  wire logic [SECTOR_BITS-1:0] sector,
   output logic                        isProtected
);

   // ************************************************************
   // Range decode
   // ************************************************************
   // Top mode compares against the complement, so no subtractor is
   // needed: sector >= 2^S - k is the same as ~sector < k.
   logic [SECTOR_BITS:0] span;
   logic [SECTOR_BITS:0] topIndex;
   logic                 inSpan;
   wire                  allSectors;
   wire                  noSectors;

   assign allSectors = protectCode >= sbp_pkg::CODE_ALL_FIRST;
   assign noSectors  = protectCode == sbp_pkg::CODE_NONE;

   always_comb begin
      span     = '0;
      topIndex = {1'b0, ~sector};
      if (!noSectors && !allSectors) begin
         span = (SECTOR_BITS+1)'(1) << (protectCode - 4'h1);
      end
      if (bottomSel) begin
         inSpan = {1'b0, sector} < span;
      end else begin
         inSpan = topIndex < span;
      end
   end

   assign isProtected = allSectors || (!noSectors && inSpan);

endmodule
`default_nettype wire

// [design/sbp_status_block.sv]
`timescale 1ns/1ps
`default_nettype none
module sbp_status_block #(
   parameter int OP_CYCLES   = sbp_pkg::OP_CYCLES,
   parameter int SECTOR_BITS = sbp_pkg::SECTOR_BITS,
   parameter int ADDR_BITS   = sbp_pkg::ADDR_BITS
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 writeProtectN,
   input  wire logic                 cmdWriteEnable,
   input  wire logic                 cmdWriteDisable,
   input  wire logic                 cmdReadStatus,
   input  wire logic                 cmdWriteStatus,
   input  wire logic [7:0]           writeStatusData,
   input  wire logic                 cmdWriteNvConfig,
   input  wire logic                 cmdProgErase,
   input  wire logic [ADDR_BITS-1:0] progEraseAddr,
   input  wire logic                 cmdDieErase,
   input  wire logic                 cmdClearFlags,
   output logic [7:0]                statusRead,
   output logic                      statusValid,
   output logic [7:0]                statusLive,
   output logic                      cmdAccepted,
   output logic                      cmdRefused,
   output logic                      protectError,
   output logic                      flagReady
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   // The counter is 16 bits wide; longer cycles would wrap.
   if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : gBadCycles
      $error("OP_CYCLES out of range");
   end
   if (ADDR_BITS != SECTOR_BITS + sbp_pkg::SECTOR_SHIFT) begin : gBadMap
      $error("address width does not match sector count");
   end

   // ************************************************************
   // State
   // ************************************************************
   sbp_pkg::sbp_state_t state_r;
   sbp_pkg::sbp_state_t state_nxt;
   logic [15:0]         count_r;
   logic [15:0]         count_nxt;
   logic                wrDisable_r;
   logic                topBottom_r;
   logic [3:0]          protBits_r;
   logic                wel_r;
   logic                wip_r;
   logic                ready_r;
   logic                pendWrite_r;
   logic [7:0]          pendData_r;
   logic [7:0]          statusRead_r;
   logic                statusValid_r;
   logic                accepted_r;
   logic                refused_r;
   logic                protErr_r;

   // ************************************************************
   // Decode
   // ************************************************************
   wire        isIdle;
   wire        cycleDone;
   wire        hwLocked;
   wire        targetProt;
   wire        protClear;
   wire        wsOk;
   wire        nvOk;
   wire        peOk;
   wire        dieOk;
   wire        protHit;
   wire        startOp;
   wire        anyWrite;
   wire        refuseNow;
   wire        setWel;
   wire        clrWel;
   wire [7:0]  liveStatus;
   wire [SECTOR_BITS-1:0] targetSector;

   assign isIdle    = state_r == sbp_pkg::SBP_IDLE;
   assign cycleDone = (state_r == sbp_pkg::SBP_BUSY) && (count_r == 16'h0001);

   // A frozen register stays frozen for as long as the pin is low.
   assign hwLocked  = wrDisable_r && !writeProtectN;

   assign targetSector = progEraseAddr[ADDR_BITS-1:sbp_pkg::SECTOR_SHIFT];

   sbp_range_decode #(
      .SECTOR_BITS (SECTOR_BITS)
   ) u_sbp_range_decode (
      .protectCode (protBits_r),
      .bottomSel   (topBottom_r),
      .sector      (targetSector),
      .isProtected (targetProt)
   );

   assign protClear = protBits_r == sbp_pkg::CODE_NONE;

   assign wsOk  = isIdle && cmdWriteStatus && wel_r && !hwLocked;
   assign nvOk  = isIdle && cmdWriteNvConfig && wel_r;
   assign peOk  = isIdle && cmdProgErase && wel_r && !targetProt;
   assign dieOk = isIdle && cmdDieErase && wel_r && protClear;

   assign protHit = isIdle && wel_r &&
                    ((cmdProgErase && targetProt) ||
                     (cmdDieErase && !protClear));

   assign startOp  = wsOk || nvOk || peOk || dieOk;
   assign anyWrite = cmdWriteStatus || cmdWriteNvConfig ||
                     cmdProgErase || cmdDieErase;

   // While busy, only reads and flag clears are served.
   assign refuseNow = (anyWrite && !startOp) ||
                      (!isIdle && (cmdWriteEnable || cmdWriteDisable));

   assign setWel = isIdle && cmdWriteEnable && !cmdWriteDisable;
   assign clrWel = (isIdle && cmdWriteDisable) || cycleDone;

   assign liveStatus = {wrDisable_r, protBits_r[3], topBottom_r,
                        protBits_r[2:0], wel_r, ~ready_r};

   // ************************************************************
   // Cycle sequencer
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         sbp_pkg::SBP_IDLE: begin
            if (startOp) begin
               state_nxt = sbp_pkg::SBP_BUSY;
               count_nxt = 16'(OP_CYCLES);
            end
         end
         sbp_pkg::SBP_BUSY: begin
            count_nxt = count_r - 16'h0001;
            if (cycleDone) begin
               state_nxt = sbp_pkg::SBP_IDLE;
            end
         end
         default: begin
            state_nxt = sbp_pkg::SBP_IDLE;
            count_nxt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= sbp_pkg::SBP_IDLE;
         count_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   // Both views of busy come from the same next state, so the
   // status bit and the flag bit never disagree.
   always_ff @(posedge clock) begin
      if (rst) begin
         wip_r   <= 1'b0;
         ready_r <= 1'b1;
      end else begin
         wip_r   <= state_nxt == sbp_pkg::SBP_BUSY;
         ready_r <= state_nxt != sbp_pkg::SBP_BUSY;
      end
   end

   // ************************************************************
   // Status register storage
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         wel_r <= sbp_pkg::STATUS_RESET[sbp_pkg::WEL_BIT];
      end else if (clrWel) begin
         wel_r <= 1'b0;
      end else if (setWel) begin
         wel_r <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pendWrite_r <= 1'b0;
         pendData_r  <= sbp_pkg::STATUS_RESET;
      end else if (wsOk) begin
         pendWrite_r <= 1'b1;
         pendData_r  <= writeStatusData;
      end else if (cycleDone) begin
         pendWrite_r <= 1'b0;
      end
   end

   // Nonvolatile bits take the new value when the write cycle ends.
   always_ff @(posedge clock) begin
      if (rst) begin
         wrDisable_r <= sbp_pkg::STATUS_RESET[sbp_pkg::WR_DISABLE_BIT];
         topBottom_r <= sbp_pkg::STATUS_RESET[sbp_pkg::TOP_BOTTOM_BIT];
         protBits_r  <= {sbp_pkg::STATUS_RESET[sbp_pkg::PROT_MSB_BIT],
                         sbp_pkg::STATUS_RESET[sbp_pkg::PROT_LO_HI_BIT:
                                               sbp_pkg::PROT_LO_LO_BIT]};
      end else if (cycleDone && pendWrite_r) begin
         wrDisable_r <= pendData_r[sbp_pkg::WR_DISABLE_BIT];
         topBottom_r <= pendData_r[sbp_pkg::TOP_BOTTOM_BIT];
         protBits_r  <= {pendData_r[sbp_pkg::PROT_MSB_BIT],
                         pendData_r[sbp_pkg::PROT_LO_HI_BIT:
                                    sbp_pkg::PROT_LO_LO_BIT]};
      end
   end

   // ************************************************************
   // Answers
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         statusRead_r  <= sbp_pkg::STATUS_RESET;
         statusValid_r <= 1'b0;
      end else begin
         statusValid_r <= cmdReadStatus;
         if (cmdReadStatus) begin
            statusRead_r <= liveStatus;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         accepted_r <= 1'b0;
         refused_r  <= 1'b0;
      end else begin
         accepted_r <= startOp;
         refused_r  <= refuseNow;
      end
   end

   // A new hit in the clearing cycle wins, so no error is lost.
   always_ff @(posedge clock) begin
      if (rst) begin
         protErr_r <= 1'b0;
      end else if (protHit) begin
         protErr_r <= 1'b1;
      end else if (cmdClearFlags) begin
         protErr_r <= 1'b0;
      end
   end

   assign statusRead   = statusRead_r;
   assign statusValid  = statusValid_r;
   assign statusLive   = {wrDisable_r, protBits_r[3], topBottom_r,
                          protBits_r[2:0], wel_r, wip_r};
   assign cmdAccepted  = accepted_r;
   assign cmdRefused   = refused_r;
   assign protectError = protErr_r;
   assign flagReady    = ready_r;

endmodule
`default_nettype wire

// [sim/sbp_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Status block checker
// ********************************
module sbp_status_monitor #(
   parameter int OP_CYCLES = 4
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        writeProtectN,
   input wire logic        cmdWriteEnable,
   input wire logic        cmdWriteDisable,
   input wire logic        cmdReadStatus,
   input wire logic        cmdWriteStatus,
   input wire logic [7:0]  writeStatusData,
   input wire logic        cmdWriteNvConfig,
   input wire logic        cmdProgErase,
   input wire logic [26:0] progEraseAddr,
   input wire logic        cmdDieErase,
   input wire logic        cmdClearFlags,
   input wire logic [7:0]  statusRead,
   input wire logic        statusValid,
   input wire logic [7:0]  statusLive,
   input wire logic        cmdAccepted,
   input wire logic        cmdRefused,
   input wire logic        protectError,
   input wire logic        flagReady
);
   int  busyCnt;
   wire logic [3:0] protCode;
   wire logic       anyWrite;
   assign protCode = {statusLive[6], statusLive[4:2]};
   assign anyWrite = cmdWriteStatus | cmdWriteNvConfig | cmdProgErase
                     | cmdDieErase;
   // Counting busy cycles keeps the length check free of long repetitions.
   always_ff @(posedge clock) begin
      if (rst || !statusLive[0]) begin
         busyCnt <= 0;
      end else begin
         busyCnt <= busyCnt + 1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_wrOk;
      cmdWriteStatus && statusLive[1] && !statusLive[0]
         && (!statusLive[7] || writeProtectN);
   endsequence
   property p_wrOk; s_wrOk |=> cmdAccepted; endproperty
   property p_frozen;
      cmdWriteStatus && statusLive[7] && !writeProtectN
         |=> cmdRefused && $stable(statusLive);
   endproperty
   property p_noWel; anyWrite && !statusLive[1] |=> cmdRefused; endproperty
   property p_read;
      cmdReadStatus |=> statusValid && statusRead == $past(statusLive);
   endproperty
   property p_noRead; !cmdReadStatus |=> !statusValid; endproperty
   property p_inv; statusLive[0] == !flagReady; endproperty
   property p_busyGo; cmdAccepted |-> statusLive[0] && !flagReady; endproperty
   property p_busyLen;
      $fell(statusLive[0]) |-> busyCnt == OP_CYCLES && !statusLive[1];
   endproperty
   property p_die; cmdDieErase && protCode != 4'h0 |=> cmdRefused; endproperty
   property p_clr;
      cmdClearFlags && !cmdProgErase && !cmdDieErase |=> !protectError;
   endproperty
   property p_perr;
      $rose(protectError) |-> $past(cmdProgErase || cmdDieErase);
   endproperty
   a_wrOk: assert property (p_wrOk) else $error("write not taken");
   a_frozen: assert property (p_frozen) else $error("frozen write");
   a_noWel: assert property (p_noWel) else $error("write w/o latch");
   a_read: assert property (p_read) else $error("read mismatch");
   a_noRead: assert property (p_noRead) else $error("stray valid");
   a_inv: assert property (p_inv) else $error("ready not inverse");
   a_busyGo: assert property (p_busyGo) else $error("busy late");
   a_busyLen: assert property (p_busyLen) else $error("busy length");
   a_die: assert property (p_die) else $error("die erase ran");
   a_perr: assert property (p_perr) else $error("stray error");
   a_clr: assert property (p_clr) else $error("flag not cleared");
endmodule
bind sbp_status_block sbp_status_monitor #(.OP_CYCLES(OP_CYCLES))
   u_sbp_status_monitor (.clock(clock), .rst(rst),
   .writeProtectN(writeProtectN), .cmdWriteEnable(cmdWriteEnable),
   .cmdWriteDisable(cmdWriteDisable), .cmdReadStatus(cmdReadStatus),
   .cmdWriteStatus(cmdWriteStatus), .writeStatusData(writeStatusData),
   .cmdWriteNvConfig(cmdWriteNvConfig), .cmdProgErase(cmdProgErase),
   .progEraseAddr(progEraseAddr), .cmdDieErase(cmdDieErase),
   .cmdClearFlags(cmdClearFlags), .statusRead(statusRead),
   .statusValid(statusValid), .statusLive(statusLive),
   .cmdAccepted(cmdAccepted), .cmdRefused(cmdRefused),
   .protectError(protectError), .flagReady(flagReady));
`default_nettype wire

// [sim/sbp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Host command driver
// ********************************
module sbp_host_model (
   input  wire logic        clock,
   input  wire logic        cmdAccepted,
   input  wire logic        cmdRefused,
   output logic             writeProtectN,
   output logic [7:0]       cmdPulse,
   output logic [7:0]       writeStatusData,
   output logic [26:0]      progEraseAddr
);
   initial begin
      cmdPulse = 8'h00;
      writeProtectN = 1'b1;
      writeStatusData = 8'h00;
      progEraseAddr = 27'h0;
   end
   task automatic setWp(input logic v);
      @(negedge clock);
      writeProtectN = v;
   endtask
   // Data and address flip once taken, so stale values cannot help.
   task automatic send(input int k, input logic [7:0] d,
                       input logic [26:0] a, output logic [1:0] ans);
      @(negedge clock);
      cmdPulse[k] = 1'b1;
      writeStatusData = d;
      progEraseAddr = a;
      @(negedge clock);
      cmdPulse = 8'h00;
      writeStatusData = ~d;
      progEraseAddr = ~a;
      ans = {cmdAccepted, cmdRefused};
   endtask
endmodule
`default_nettype wire

// [sim/sbp_status_block_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Status block bench
// ********************************
module sbp_status_block_bench;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        writeProtectN;
   logic [7:0]  cmdPulse, writeStatusData, statusRead, statusLive;
   logic [26:0] progEraseAddr;
   logic        statusValid, cmdAccepted, cmdRefused, protectError;
   logic        flagReady;
   logic [1:0]  ans;
   int          err_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #5 clock = ~clock;
   sbp_status_block #(.OP_CYCLES(4)) u_sbp_status_block (
      .clock(clock), .rst(rst), .writeProtectN(writeProtectN),
      .cmdWriteEnable(cmdPulse[0]), .cmdWriteDisable(cmdPulse[1]),
      .cmdReadStatus(cmdPulse[2]), .cmdClearFlags(cmdPulse[3]),
      .cmdWriteStatus(cmdPulse[4]), .cmdWriteNvConfig(cmdPulse[5]),
      .cmdProgErase(cmdPulse[6]), .cmdDieErase(cmdPulse[7]),
      .writeStatusData(writeStatusData), .progEraseAddr(progEraseAddr),
      .statusRead(statusRead), .statusValid(statusValid),
      .statusLive(statusLive), .cmdAccepted(cmdAccepted),
      .cmdRefused(cmdRefused), .protectError(protectError),
      .flagReady(flagReady));
   sbp_host_model u_sbp_host_model (
      .clock(clock), .cmdAccepted(cmdAccepted), .cmdRefused(cmdRefused),
      .writeProtectN(writeProtectN), .cmdPulse(cmdPulse),
      .writeStatusData(writeStatusData), .progEraseAddr(progEraseAddr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic cmd(input int k, input logic [7:0] d,
                      input logic [26:0] a, input logic [1:0] exp);
      u_sbp_host_model.send(k, d, a, ans);
      check(ans, exp, "answer");
   endtask
   task automatic idle();
      for (int i = 0; i < 20 && flagReady !== 1'b1; i++) @(negedge clock);
      check(flagReady, 1'b1, "ready");
   endtask
   task automatic wstat(input logic [7:0] d);
      cmd(0, 8'h00, 27'h0, 2'b00);
      cmd(4, d, 27'h0, 2'b10);
      idle();
      cmd(2, 8'h00, 27'h0, 2'b00);
      check({statusValid, statusRead}, {1'b1, d[7:2], 2'b00}, "read");
   endtask
   // A refused target must leave the latch set and raise the error flag.
   task automatic prog(input int s, input logic hit);
      cmd(0, 8'h00, 27'h0, 2'b00);
      cmd(6, 8'h00, {s[10:0], hit ? 16'h0000 : 16'hffff},
          hit ? 2'b01 : 2'b10);
      if (hit) begin
         check({protectError, statusLive[1]}, 2'b11, "hit");
         cmd(3, 8'h00, 27'h0, 2'b00);
         cmd(1, 8'h00, 27'h0, 2'b00);
         check({protectError, statusLive[1]}, 2'b00, "clear");
      end
      idle();
   endtask
   initial begin
      int sz;
      int p;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      check({statusLive, flagReady}, 9'h001, "reset");
      cmd(4, 8'h04, 27'h0, 2'b01);
      cmd(5, 8'h00, 27'h0, 2'b01);
      cmd(0, 8'h00, 27'h0, 2'b00);
      cmd(5, 8'h00, 27'h0, 2'b10);
      cmd(4, 8'h04, 27'h0, 2'b01);
      cmd(0, 8'h00, 27'h0, 2'b01);
      idle();
      check(statusLive, 8'h00, "latch");
      for (int tb = 0; tb < 2; tb++) begin
         for (int n = 0; n < 16; n++) begin
            sz = n == 0 ? 0 : n >= 12 ? 2048 : 1 << (n - 1);
            wstat({1'b0, n[3], tb[0], n[2:0], 2'b00});
            cmd(0, 8'h00, 27'h0, 2'b00);
            cmd(7, 8'h00, 27'h0, n == 0 ? 2'b10 : 2'b01);
            cmd(3, 8'h00, 27'h0, 2'b00);
            idle();
            if (n != 0) begin
               p = tb ? sz - 1 : 2048 - sz;
               prog(p, 1'b1);
               if (sz < 2048) prog(tb ? sz : p - 1, 1'b0);
               else prog(tb ? 0 : 2047, 1'b1);
            end
         end
      end
      wstat(8'h80);
      u_sbp_host_model.setWp(1'b0);
      cmd(0, 8'h00, 27'h0, 2'b00);
      cmd(4, 8'h00, 27'h0, 2'b01);
      check(statusLive, 8'h82, "frozen");
      u_sbp_host_model.setWp(1'b1);
      cmd(4, 8'h00, 27'h0, 2'b10);
      idle();
      check(statusLive, 8'h00, "unfrozen");
      stop_test();
   end
endmodule
`default_nettype wire
